// ==== rtl/ifm_map.vh ====
// register offsets, field positions, reset values and sizes of the image format stage
`ifndef IFM_MAP_VH
`define IFM_MAP_VH

// register byte offsets
`define IFM_REG_CTRL        6'h00
`define IFM_REG_COL_KEEP    6'h04
`define IFM_REG_ROW_KEEP    6'h08
`define IFM_REG_DROP_METHOD 6'h0c
`define IFM_REG_OUT_COLS    6'h10
`define IFM_REG_OUT_ROWS    6'h14
`define IFM_REG_ROI_COL     6'h18
`define IFM_REG_ROI_ROW     6'h1c
`define IFM_REG_PATTERN     6'h20
`define IFM_REG_BIN         6'h24
`define IFM_REG_ARRAY_COLS  6'h28
`define IFM_REG_ARRAY_ROWS  6'h2c
`define IFM_REG_MAX_COLS    6'h30
`define IFM_REG_MAX_ROWS    6'h34
`define IFM_REG_STATUS      6'h38

// control register fields
`define IFM_CTRL_FLIP_X     0
`define IFM_CTRL_FLIP_Y     1
`define IFM_CTRL_LAYER      2
`define IFM_CTRL_GEN        3
`define IFM_CTRL_ADC_LO     4
`define IFM_CTRL_ADC_HI     5

// status register fields
`define IFM_STAT_BAYER_LO   0
`define IFM_STAT_BAYER_HI   1
`define IFM_STAT_BIN_ON     2
`define IFM_STAT_READING    3

// sensor array size and reset values
`define IFM_ARRAY_COLS      12'd2472
`define IFM_ARRAY_ROWS      12'd2064
`define IFM_RST_KEEP        8'h01
`define IFM_RST_BIN         4'h1
`define IFM_DROP_DISCARD    2'h0
`define IFM_PAT_OFF         2'h0
`define IFM_PAT_COL_RAMP    2'h1
`define IFM_PAT_ROW_RAMP    2'h2
`define IFM_PAT_DIAG        2'h3

`endif

// ==== rtl/ifm_line_mem.v ====
// two-bank line store with registered read data
`timescale 1ns/100ps
`default_nettype none
module ifm_line_mem #(
   parameter DW = 16,
   parameter AW = 13
) (
   // clock
   input  wire          clk_i,
   // write port
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [DW-1:0] wdata_i,
   // read port
   input  wire [AW-1:0] raddr_i,
   output reg  [DW-1:0] rdata_o
);

   reg [DW-1:0] mem_ff [0:(1<<AW)-1];

   // no reset on the array so it maps to block ram
   always @(posedge clk_i) begin
      if (we_i) begin
         mem_ff[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_ff[raddr_i];
   end

endmodule
`default_nettype wire

// ==== rtl/ifm_format.v ====
// image format stage: decimation, flips, roi crop, test patterns and size report
`timescale 1ns/100ps
`default_nettype none
`include "ifm_map.vh"
module ifm_format #(
   parameter DW    = 16,
   parameter CW    = 12,
   parameter FW    = 8,
   parameter COLOR = 1
) (
   // clock and reset
   input  wire          REF_CLK_I,
   input  wire          RSTN_I,
   // avalon-mm register slave
   input  wire [5:0]    AVS_ADDRESS_I,
   input  wire          AVS_READ_I,
   input  wire          AVS_WRITE_I,
   input  wire [31:0]   AVS_WRITEDATA_I,
   input  wire [3:0]    AVS_BYTEENABLE_I,
   output reg  [31:0]   AVS_READDATA_O,
   output wire          AVS_WAITREQUEST_O,
   // sensor pixel stream
   input  wire          SNS_VALID_I,
   input  wire [DW-1:0] SNS_DATA_I,
   input  wire          SNS_SOF_I,
   input  wire          SNS_EOL_I,
   // controls to sensor readout and binning engine
   output wire          ROWS_REVERSED_O,
   output wire [1:0]    ADC_DEPTH_O,
   output wire          BIN_EN_O,
   output wire [3:0]    BIN_H_O,
   output wire [3:0]    BIN_V_O,
   output wire [1:0]    BAYER_PHASE_O,
   // output pixel stream
   output reg           PIX_VALID_O,
   output reg  [DW-1:0] PIX_DATA_O,
   output reg           PIX_SOF_O,
   output reg           PIX_EOL_O
);

   // register file
   reg [5:0]    ctrl_ff;
   reg [FW-1:0] col_keep0_ff;
   reg [FW-1:0] col_keep1_ff;
   reg [FW-1:0] row_keep0_ff;
   reg [FW-1:0] row_keep1_ff;
   reg [CW-1:0] out_cols_ff;
   reg [CW-1:0] out_rows_ff;
   reg [CW-1:0] roi_col_start_ff;
   reg [CW-1:0] roi_row_start_ff;
   reg [1:0]    pattern_kind0_ff;
   reg [1:0]    pattern_kind1_ff;
   reg [3:0]    bin_h_ff;
   reg [3:0]    bin_v_ff;
   reg          rd_ack_ff;
   reg [31:0]   rd_word;
   reg [31:0]   wr_word;

   // frame shadows, so a write mid-frame cannot tear an image
   reg [FW-1:0] col_n0_ff;
   reg [FW-1:0] col_n1_ff;
   reg [FW-1:0] row_n0_ff;
   reg [FW-1:0] row_n1_ff;
   reg          flip_x_ff;
   reg [CW-1:0] roi_c_ff;
   reg [CW-1:0] roi_r_ff;
   reg [CW-1:0] w_ff;
   reg [CW-1:0] h_ff;
   reg [1:0]    pat_in_ff;
   reg [1:0]    pat_out_ff;

   // input side counters
   reg [FW-1:0] cdiv0_ff;
   reg [FW-1:0] cdiv1_ff;
   reg [FW-1:0] rdiv0_ff;
   reg [FW-1:0] rdiv1_ff;
   reg [CW-1:0] in_col_ff;
   reg [CW-1:0] in_row_ff;
   reg [CW-1:0] wptr_ff;
   reg          wbank_ff;
   reg [CW-1:0] kept_row_ff;

   // reader side
   reg          rd_act_ff;
   reg          rbank_ff;
   reg [CW-1:0] rlen_ff;
   reg [CW-1:0] ridx_ff;
   reg          rrow_ok_ff;
   reg [CW-1:0] rrow_ff;
   reg          first_ff;
   reg          s1_valid_ff;
   reg          s1_sof_ff;
   reg          s1_eol_ff;
   reg [CW-1:0] s1_col_ff;
   reg [CW-1:0] s1_row_ff;

   wire [DW-1:0] mem_rdata;

   // counter wrap for a window of n, zero counts as one
   function [FW-1:0] wrap_next;
      input [FW-1:0] cnt;
      input [FW-1:0] n;
      begin
         if (n <= {{(FW-1){1'b0}}, 1'b1} || cnt + {{(FW-1){1'b0}}, 1'b1} >= n) begin
            wrap_next = {FW{1'b0}};
         end else begin
            wrap_next = cnt + {{(FW-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   // generated test pixel for a column and row
   function [DW-1:0] pattern_pix;
      input [1:0]    kind;
      input [CW-1:0] col;
      input [CW-1:0] row;
      input [DW-1:0] live;
      reg   [CW-1:0] sum;
      begin
         sum = col + row;
         case (kind)
            `IFM_PAT_COL_RAMP: pattern_pix = {{(DW-CW){1'b0}}, col};
            `IFM_PAT_ROW_RAMP: pattern_pix = {{(DW-CW){1'b0}}, row};
            `IFM_PAT_DIAG:     pattern_pix = {{(DW-CW){1'b0}}, sum};
            default:           pattern_pix = live;
         endcase
      end
   endfunction

   // size after a binning factor of 1 to 4, others act as 1
   function [CW-1:0] binned;
      input [CW-1:0] total;
      input [3:0]    f;
      begin
         case (f)
            4'h2:    binned = total / 4'h2;  // sized divisor keeps the quotient at CW bits
            4'h3:    binned = total / 4'h3;
            4'h4:    binned = total / 4'h4;
            default: binned = total;
         endcase
      end
   endfunction

   // byte lane merge of a write into the old word
   function [31:0] be_merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  be;
      integer      k;
      begin
         be_merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k]) begin
               be_merge[8*k +: 8] = data[8*k +: 8];
            end
         end
      end
   endfunction

   wire layer_sel = ctrl_ff[`IFM_CTRL_LAYER];
   wire gen_sel   = ctrl_ff[`IFM_CTRL_GEN];
   wire decim_off = (col_keep0_ff <= `IFM_RST_KEEP) && (col_keep1_ff <= `IFM_RST_KEEP) &&
                    (row_keep0_ff <= `IFM_RST_KEEP) && (row_keep1_ff <= `IFM_RST_KEEP);
   wire bin_any   = (bin_h_ff > `IFM_RST_BIN) || (bin_v_ff > `IFM_RST_BIN);

   // binning engine only runs while no decimation layer is active
   assign BIN_EN_O = decim_off && bin_any;
   assign BIN_H_O  = decim_off ? bin_h_ff : `IFM_RST_BIN;
   assign BIN_V_O  = decim_off ? bin_v_ff : `IFM_RST_BIN;
   assign ROWS_REVERSED_O = ctrl_ff[`IFM_CTRL_FLIP_Y];
   // converter depth goes to the readout; deeper conversions lengthen each row
   assign ADC_DEPTH_O = ctrl_ff[`IFM_CTRL_ADC_HI:`IFM_CTRL_ADC_LO];
   // reported colour order: bit 0 column phase, bit 1 row phase
   assign BAYER_PHASE_O = (COLOR != 0) ?
                          {ctrl_ff[`IFM_CTRL_FLIP_Y], ctrl_ff[`IFM_CTRL_FLIP_X]} : 2'h0;

   wire [CW-1:0] max_cols = binned(`IFM_ARRAY_COLS, BIN_H_O);
   wire [CW-1:0] max_rows = binned(`IFM_ARRAY_ROWS, BIN_V_O);

   // reads wait one cycle so read data come from a flop
   assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_ack_ff;

   // read decode; keep factor and pattern registers show the selected bank
   always @* begin
      rd_word = 32'h0;
      case (AVS_ADDRESS_I)
         `IFM_REG_CTRL:        rd_word[5:0] = ctrl_ff;
         `IFM_REG_COL_KEEP:    rd_word[FW-1:0] = layer_sel ? col_keep1_ff : col_keep0_ff;
         `IFM_REG_ROW_KEEP:    rd_word[FW-1:0] = layer_sel ? row_keep1_ff : row_keep0_ff;
         `IFM_REG_DROP_METHOD: rd_word[1:0] = `IFM_DROP_DISCARD;
         `IFM_REG_OUT_COLS:    rd_word[CW-1:0] = out_cols_ff;
         `IFM_REG_OUT_ROWS:    rd_word[CW-1:0] = out_rows_ff;
         `IFM_REG_ROI_COL:     rd_word[CW-1:0] = roi_col_start_ff;
         `IFM_REG_ROI_ROW:     rd_word[CW-1:0] = roi_row_start_ff;
         `IFM_REG_PATTERN:     rd_word[1:0] = gen_sel ? pattern_kind1_ff : pattern_kind0_ff;
         `IFM_REG_BIN:         rd_word[7:0] = {bin_v_ff, bin_h_ff};
         `IFM_REG_ARRAY_COLS:  rd_word[CW-1:0] = `IFM_ARRAY_COLS;
         `IFM_REG_ARRAY_ROWS:  rd_word[CW-1:0] = `IFM_ARRAY_ROWS;
         `IFM_REG_MAX_COLS:    rd_word[CW-1:0] = max_cols;
         `IFM_REG_MAX_ROWS:    rd_word[CW-1:0] = max_rows;
         `IFM_REG_STATUS:      rd_word[3:0] = {rd_act_ff, BIN_EN_O, BAYER_PHASE_O};
         default:              rd_word = 32'h0;
      endcase
      wr_word = be_merge(rd_word, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
   end

   // register writes take effect at the first edge; zero keep factors are refused, zero binning factors are stored
   always @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctrl_ff          <= 6'h0;
         col_keep0_ff     <= `IFM_RST_KEEP;
         col_keep1_ff     <= `IFM_RST_KEEP;
         row_keep0_ff     <= `IFM_RST_KEEP;
         row_keep1_ff     <= `IFM_RST_KEEP;
         out_cols_ff      <= `IFM_ARRAY_COLS;
         out_rows_ff      <= `IFM_ARRAY_ROWS;
         roi_col_start_ff <= {CW{1'b0}};
         roi_row_start_ff <= {CW{1'b0}};
         pattern_kind0_ff <= `IFM_PAT_OFF;
         pattern_kind1_ff <= `IFM_PAT_OFF;
         bin_h_ff         <= `IFM_RST_BIN;
         bin_v_ff         <= `IFM_RST_BIN;
         rd_ack_ff        <= 1'b0;
         AVS_READDATA_O   <= 32'h0;
      end else begin
         rd_ack_ff <= AVS_READ_I && !rd_ack_ff;
         if (AVS_READ_I && !rd_ack_ff) begin
            AVS_READDATA_O <= rd_word;
         end
         if (AVS_WRITE_I) begin
            case (AVS_ADDRESS_I)
               `IFM_REG_CTRL: ctrl_ff <= wr_word[5:0];
               `IFM_REG_COL_KEEP: begin
                  if (wr_word[FW-1:0] != {FW{1'b0}} && layer_sel) begin
                     col_keep1_ff <= wr_word[FW-1:0];
                  end else if (wr_word[FW-1:0] != {FW{1'b0}}) begin
                     col_keep0_ff <= wr_word[FW-1:0];
                  end
               end
               `IFM_REG_ROW_KEEP: begin
                  if (wr_word[FW-1:0] != {FW{1'b0}} && layer_sel) begin
                     row_keep1_ff <= wr_word[FW-1:0];
                  end else if (wr_word[FW-1:0] != {FW{1'b0}}) begin
                     row_keep0_ff <= wr_word[FW-1:0];
                  end
               end
               `IFM_REG_OUT_COLS: out_cols_ff      <= wr_word[CW-1:0];
               `IFM_REG_OUT_ROWS: out_rows_ff      <= wr_word[CW-1:0];
               `IFM_REG_ROI_COL:  roi_col_start_ff <= wr_word[CW-1:0];
               `IFM_REG_ROI_ROW:  roi_row_start_ff <= wr_word[CW-1:0];
               `IFM_REG_PATTERN: begin
                  if (gen_sel) begin
                     pattern_kind1_ff <= wr_word[1:0];
                  end else begin
                     pattern_kind0_ff <= wr_word[1:0];
                  end
               end
               `IFM_REG_BIN: begin
                  bin_h_ff <= wr_word[3:0];
                  bin_v_ff <= wr_word[7:4];
               end
               default: ctrl_ff <= ctrl_ff;
            endcase
         end
      end
   end

   // pixel position inside the incoming raster; sof forces the origin
   wire [FW-1:0] c0  = SNS_SOF_I ? {FW{1'b0}} : cdiv0_ff;
   wire [FW-1:0] c1  = SNS_SOF_I ? {FW{1'b0}} : cdiv1_ff;
   wire [FW-1:0] r0  = SNS_SOF_I ? {FW{1'b0}} : rdiv0_ff;
   wire [FW-1:0] r1  = SNS_SOF_I ? {FW{1'b0}} : rdiv1_ff;
   wire [CW-1:0] icol = SNS_SOF_I ? {CW{1'b0}} : in_col_ff;
   wire [CW-1:0] irow = SNS_SOF_I ? {CW{1'b0}} : in_row_ff;
   wire [CW-1:0] wptr = SNS_SOF_I ? {CW{1'b0}} : wptr_ff;
   wire [CW-1:0] krow = SNS_SOF_I ? {CW{1'b0}} : kept_row_ff;
   wire [FW-1:0] cn0  = SNS_SOF_I ? col_keep0_ff : col_n0_ff;
   wire [FW-1:0] rn0  = SNS_SOF_I ? row_keep0_ff : row_n0_ff;

   // the two layers cascade: a pixel survives only if both layers keep it
   wire col_keep = (c0 == {FW{1'b0}}) && (c1 == {FW{1'b0}});
   wire row_keep = (r0 == {FW{1'b0}}) && (r1 == {FW{1'b0}});
   wire take     = SNS_VALID_I && col_keep && row_keep;
   wire line_end = SNS_VALID_I && SNS_EOL_I && row_keep;
   wire [1:0]    pat_in  = SNS_SOF_I ? pattern_kind0_ff : pat_in_ff;
   wire [DW-1:0] wdata   = pattern_pix(pat_in, icol, irow, SNS_DATA_I);
   wire [CW-1:0] wlen    = wptr + {{(CW-1){1'b0}}, col_keep};

   // row inside the roi, judged on the kept and already flipped row order
   wire [CW-1:0] roi_r   = SNS_SOF_I ? roi_row_start_ff : roi_r_ff;
   wire [CW-1:0] hgt     = SNS_SOF_I ? out_rows_ff : h_ff;
   wire          row_ok  = (krow >= roi_r) && (krow - roi_r < hgt);

   // input side: decimation counters and line store writes
   always @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cdiv0_ff <= {FW{1'b0}};
         cdiv1_ff <= {FW{1'b0}};
         rdiv0_ff <= {FW{1'b0}};
         rdiv1_ff <= {FW{1'b0}};
         in_col_ff <= {CW{1'b0}};
         in_row_ff <= {CW{1'b0}};
         wptr_ff <= {CW{1'b0}};
         wbank_ff <= 1'b0;
         kept_row_ff <= {CW{1'b0}};
         col_n0_ff <= `IFM_RST_KEEP;
         col_n1_ff <= `IFM_RST_KEEP;
         row_n0_ff <= `IFM_RST_KEEP;
         row_n1_ff <= `IFM_RST_KEEP;
         flip_x_ff <= 1'b0;
         roi_c_ff <= {CW{1'b0}};
         roi_r_ff <= {CW{1'b0}};
         w_ff <= `IFM_ARRAY_COLS;
         h_ff <= `IFM_ARRAY_ROWS;
         pat_in_ff <= `IFM_PAT_OFF;
         pat_out_ff <= `IFM_PAT_OFF;
      end else if (SNS_VALID_I) begin
         if (SNS_SOF_I) begin
            col_n0_ff  <= col_keep0_ff;
            col_n1_ff  <= col_keep1_ff;
            row_n0_ff  <= row_keep0_ff;
            row_n1_ff  <= row_keep1_ff;
            flip_x_ff  <= ctrl_ff[`IFM_CTRL_FLIP_X];
            roi_c_ff   <= roi_col_start_ff;
            roi_r_ff   <= roi_row_start_ff;
            w_ff       <= out_cols_ff;
            h_ff       <= out_rows_ff;
            pat_in_ff  <= pattern_kind0_ff;
            pat_out_ff <= pattern_kind1_ff;
         end
         if (SNS_EOL_I) begin
            cdiv0_ff  <= {FW{1'b0}};
            cdiv1_ff  <= {FW{1'b0}};
            in_col_ff <= {CW{1'b0}};
            in_row_ff <= irow + {{(CW-1){1'b0}}, 1'b1};
            wptr_ff   <= {CW{1'b0}};
            rdiv0_ff  <= wrap_next(r0, rn0);
            if (wrap_next(r0, rn0) == {FW{1'b0}}) begin
               rdiv1_ff <= wrap_next(r1, SNS_SOF_I ? row_keep1_ff : row_n1_ff);
            end else begin
               rdiv1_ff <= r1;
            end
            if (row_keep) begin
               wbank_ff    <= ~wbank_ff;
               kept_row_ff <= krow + {{(CW-1){1'b0}}, 1'b1};
            end else begin
               kept_row_ff <= krow;
            end
         end else begin
            in_col_ff <= icol + {{(CW-1){1'b0}}, 1'b1};
            in_row_ff <= irow;
            cdiv0_ff  <= wrap_next(c0, cn0);
            if (wrap_next(c0, cn0) == {FW{1'b0}}) begin
               cdiv1_ff <= wrap_next(c1, SNS_SOF_I ? col_keep1_ff : col_n1_ff);
            end else begin
               cdiv1_ff <= c1;
            end
            rdiv0_ff    <= r0;
            rdiv1_ff    <= r1;
            kept_row_ff <= krow;
            wptr_ff     <= take ? wlen : wptr;
         end
      end
   end

   // reader: replays the finished line, reversed when flipping
   wire [CW-1:0] rlast = rlen_ff - {{(CW-1){1'b0}}, 1'b1};
   wire [CW-1:0] raddr = flip_x_ff ? (rlast - ridx_ff) : ridx_ff;
   // crop on the flipped index; host keeps roi inside the line
   wire          col_ok = (ridx_ff >= roi_c_ff) && (ridx_ff - roi_c_ff < w_ff);
   wire          col_end = (ridx_ff - roi_c_ff == w_ff - {{(CW-1){1'b0}}, 1'b1}) ||
                           (ridx_ff == rlast);

   always @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rd_act_ff   <= 1'b0;
         rbank_ff    <= 1'b0;
         rlen_ff     <= {CW{1'b0}};
         ridx_ff     <= {CW{1'b0}};
         rrow_ok_ff  <= 1'b0;
         rrow_ff     <= {CW{1'b0}};
         first_ff    <= 1'b0;
         s1_valid_ff <= 1'b0;
         s1_sof_ff   <= 1'b0;
         s1_eol_ff   <= 1'b0;
         s1_col_ff   <= {CW{1'b0}};
         s1_row_ff   <= {CW{1'b0}};
      end else begin
         s1_valid_ff <= rd_act_ff && rrow_ok_ff && col_ok;
         s1_sof_ff   <= rd_act_ff && rrow_ok_ff && col_ok && first_ff;
         s1_eol_ff   <= rd_act_ff && rrow_ok_ff && col_ok && col_end;
         s1_col_ff   <= ridx_ff - roi_c_ff;
         s1_row_ff   <= rrow_ff;
         // a line of zero kept pixels starts no replay
         if (line_end && wlen != {CW{1'b0}}) begin
            rd_act_ff  <= 1'b1;
            rbank_ff   <= wbank_ff;
            rlen_ff    <= wlen;
            ridx_ff    <= {CW{1'b0}};
            rrow_ok_ff <= row_ok;
            rrow_ff    <= krow - roi_r;
         end else if (rd_act_ff) begin
            ridx_ff   <= ridx_ff + {{(CW-1){1'b0}}, 1'b1};
            rd_act_ff <= (ridx_ff != rlast);
         end
         if (SNS_VALID_I && SNS_SOF_I) begin
            first_ff <= 1'b1;
         end else if (rd_act_ff && rrow_ok_ff && col_ok) begin
            first_ff <= 1'b0;
         end
      end
   end

   // output stage; the second generator replaces cropped pixels
   always @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PIX_VALID_O <= 1'b0;
         PIX_DATA_O  <= {DW{1'b0}};
         PIX_SOF_O   <= 1'b0;
         PIX_EOL_O   <= 1'b0;
      end else begin
         PIX_VALID_O <= s1_valid_ff;
         PIX_SOF_O   <= s1_sof_ff;
         PIX_EOL_O   <= s1_eol_ff;
         PIX_DATA_O  <= pattern_pix(pat_out_ff, s1_col_ff, s1_row_ff, mem_rdata);
      end
   end

   ifm_line_mem #(
      .DW (DW),
      .AW (CW+1)
   ) u_line_mem (
      .clk_i   (REF_CLK_I),
      .we_i    (take),
      .waddr_i ({wbank_ff, wptr}),
      .wdata_i (wdata),
      .raddr_i ({rbank_ff, raddr}),
      .rdata_o (mem_rdata)
   );

endmodule
`default_nettype wire

// ==== test/ifm_checker.sv ====
// port assertions for the image format stage
`timescale 1ns/100ps
`default_nettype none
module ifm_checker (
   // clock, reset and bus
   input wire logic       REF_CLK_I,
   input wire logic       RSTN_I,
   input wire logic [5:0] AVS_ADDRESS_I,
   input wire logic       AVS_READ_I,
   input wire logic       AVS_WRITE_I,
   input wire logic       AVS_WAITREQUEST_O,
   // controls and output stream
   input wire logic       ROWS_REVERSED_O,
   input wire logic [1:0] ADC_DEPTH_O,
   input wire logic       BIN_EN_O,
   input wire logic [3:0] BIN_H_O,
   input wire logic [3:0] BIN_V_O,
   input wire logic [1:0] BAYER_PHASE_O,
   input wire logic       PIX_VALID_O,
   input wire logic       PIX_SOF_O,
   input wire logic       PIX_EOL_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // writes never stall, reads stall exactly one cycle
   property p_wr_go; AVS_WRITE_I |-> !AVS_WAITREQUEST_O; endproperty
   a_wr_go: assert property (p_wr_go) else $error("write stalled");
   property p_rd_one; $rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O; endproperty
   a_rd_one: assert property (p_rd_one) else $error("read stall length wrong");
   property p_wait_rd; AVS_WAITREQUEST_O |-> AVS_READ_I; endproperty
   a_wait_rd: assert property (p_wait_rd) else $error("stall without read");
   // binning runs only while its factors pass through, i.e. decimation is off
   property p_bin; BIN_EN_O == (BIN_H_O != 4'h1 || BIN_V_O != 4'h1); endproperty
   a_bin: assert property (p_bin) else $error("binning enable wrong");
   property p_phase; BAYER_PHASE_O[1] == ROWS_REVERSED_O; endproperty
   a_phase: assert property (p_phase) else $error("row phase wrong");
   // settings pins move only after a control write
   property p_depth;
      !$stable(ADC_DEPTH_O) |-> $past(AVS_WRITE_I) && $past(AVS_ADDRESS_I) == 6'h00;
   endproperty
   a_depth: assert property (p_depth) else $error("depth moved alone");
   property p_rows;
      !$stable(ROWS_REVERSED_O) |-> $past(AVS_WRITE_I) && $past(AVS_ADDRESS_I) == 6'h00;
   endproperty
   a_rows: assert property (p_rows) else $error("row order moved alone");
   // a cropped row leaves as one unbroken burst
   property p_run; PIX_VALID_O && !PIX_EOL_O |=> PIX_VALID_O; endproperty
   a_run: assert property (p_run) else $error("row burst broken");
   property p_mark; PIX_SOF_O || PIX_EOL_O |-> PIX_VALID_O; endproperty
   a_mark: assert property (p_mark) else $error("mark without pixel");
endmodule
`default_nettype wire

// ==== test/ifm_sensor_model.sv ====
// behavioural sensor readout for a small pixel array
`timescale 1ns/100ps
`default_nettype none
module ifm_sensor_model #(parameter L = 12, parameter H = 8) (
   // clock and control
   input  wire logic    clk_i,
   input  wire logic    start_i,
   input  wire logic    rows_rev_i,
   // pixel stream
   output logic         valid_o,
   output logic [15:0]  data_o,
   output logic         sof_o,
   output logic         eol_o,
   output logic         busy_o
);
   integer seed = 7, r, c, p;
   // one frame per start; random idle gaps, data scrambled while idle
   initial begin
      {valid_o, sof_o, eol_o, busy_o, data_o} = 20'h0;
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            busy_o <= 1'b1;
            for (r = 0; r < H; r++) for (c = 0; c < L; c++) begin
               while (($random(seed) & 3) == 0) begin
                  {valid_o, sof_o, eol_o} <= 3'h0;
                  data_o <= ~data_o;
                  @(posedge clk_i);
               end
               p = rows_rev_i ? H - 1 - r : r;
               {valid_o, sof_o, eol_o} <= {1'b1, r == 0 && c == 0, c == L - 1};
               data_o <= 16'h8000 + 16'(p * 256 + c);
               @(posedge clk_i);
            end
            {valid_o, sof_o, eol_o, busy_o} <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/ifm_format_tb.sv ====
// self-checking bench for the image format stage
`timescale 1ns/100ps
`default_nettype none
`include "ifm_map.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module ifm_format_tb;
   logic        clk = 0, rst_n = 0, rd = 0, wr = 0, start = 0;
   logic [5:0]  addr = 0;
   logic [31:0] wdata = 0, q, x;
   wire  [31:0] rdata;
   wire  [15:0] sd, pd;
   wire  [3:0]  bh, bv;
   wire  [1:0]  adc, ph;
   wire         wreq, rrev, bin_en, sv, ss, se, busy, pv, ps, pe;
   logic [15:0] got[$], exp_q[$];
   integer      bad_count = 0, n_tests = 0, seed = 92583, n_sof, n_eol;
   integer      f, i, j, ec, er, nk, nr, rc, oc, rr, orr, p0 = 0, p1 = 0;
   logic [5:0]  ra[7] = '{`IFM_REG_ARRAY_COLS, `IFM_REG_ARRAY_ROWS, `IFM_REG_OUT_COLS,
                          `IFM_REG_MAX_ROWS, `IFM_REG_ROW_KEEP, `IFM_REG_DROP_METHOD, 6'h3c};
   integer      rv[7] = '{2472, 2064, 2472, 2064, 1, 0, 0};
   ifm_format u_ifm_format (.REF_CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .SNS_VALID_I(sv), .SNS_DATA_I(sd),
      .SNS_SOF_I(ss), .SNS_EOL_I(se), .ROWS_REVERSED_O(rrev), .ADC_DEPTH_O(adc),
      .BIN_EN_O(bin_en), .BIN_H_O(bh), .BIN_V_O(bv), .BAYER_PHASE_O(ph), .PIX_VALID_O(pv),
      .PIX_DATA_O(pd), .PIX_SOF_O(ps), .PIX_EOL_O(pe));
   ifm_sensor_model u_ifm_sensor_model (.clk_i(clk), .start_i(start), .rows_rev_i(rrev),
      .valid_o(sv), .data_o(sd), .sof_o(ss), .eol_o(se), .busy_o(busy));
   always #4 clk = ~clk;
   // collect output pixels and framing marks
   always @(posedge clk) if (pv === 1'b1) begin
      got.push_back(pd);
      n_sof += ps;
      n_eol += pe;
   end
   // one bus cycle, held until waitrequest is seen low at an edge
   task bus(input logic r, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      {rd, wr, addr, wdata} <= {r, !r, a, d};
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      {rd, wr} <= 2'b00;
   endtask
   // expected pixel: sensor value or the selected ramp
   function automatic logic [15:0] pix(int s, int c, logic fy, int pt);
      case (pt)
         0: pix = 16'h8000 + 16'((fy ? 7 - s : s) * 256 + c);
         1: pix = 16'(c);
         2: pix = 16'(s);
         default: pix = 16'(c + s);
      endcase
   endfunction
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog well beyond the few thousand cycles the run needs
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      results;
   end
   // reset values, binning against decimation, then random frames
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      bus(0, `IFM_REG_ARRAY_COLS, 0);
      bus(0, `IFM_REG_DROP_METHOD, 1);
      foreach (ra[k]) begin bus(1, ra[k], 0); `CHK("reg", rv[k], q) end
      bus(0, `IFM_REG_BIN, 32'h22);
      bus(0, `IFM_REG_ROI_COL, 5);
      bus(1, `IFM_REG_MAX_COLS, 0); `CHK("max cols", 1236, q)
      bus(1, `IFM_REG_MAX_ROWS, 0); `CHK("max rows", 1032, q)
      `CHK("bin on", 1'b1, bin_en)
      bus(0, `IFM_REG_COL_KEEP, 2);
      bus(1, `IFM_REG_MAX_COLS, 0); `CHK("bin off", 1'b0, bin_en)
      `CHK("max cols", 2472, q)
      bus(0, `IFM_REG_BIN, 32'h11);
      $display("register test done");
      for (f = 0; f < 12; f++) begin
         x = f ? $random(seed) : 0;
         ec = (1 + x[1]) * (1 + x[2]);
         er = (1 + x[3]) * (1 + x[4]);
         nk = (11 + ec) / ec;
         nr = (7 + er) / er;
         rc = x[13:10] % nk;
         oc = f ? 1 + x[19:14] % (nk - rc) : nk;
         rr = x[22:20] % nr;
         orr = f ? 1 + x[27:23] % (nr - rr) : nr;
         bus(0, `IFM_REG_CTRL, 0);
         bus(0, `IFM_REG_COL_KEEP, 1 + x[1]);
         bus(0, `IFM_REG_ROW_KEEP, 1 + x[3]);
         bus(0, `IFM_REG_CTRL, 4);
         bus(0, `IFM_REG_COL_KEEP, 1 + x[2]);
         bus(0, `IFM_REG_ROW_KEEP, 1 + x[4]);
         bus(0, `IFM_REG_CTRL, {x[29:28], x[6], 1'b0, x[5], x[0]});
         bus(0, `IFM_REG_PATTERN, f % 4);
         // the generator selector decides which bank the pattern lands in
         if (x[6]) p1 = f % 4;
         else p0 = f % 4;
         bus(0, `IFM_REG_OUT_COLS, oc);
         bus(0, `IFM_REG_OUT_ROWS, orr);
         bus(0, `IFM_REG_ROI_COL, rc);
         bus(0, `IFM_REG_ROI_ROW, rr);
         bus(1, `IFM_REG_MAX_COLS, 0); `CHK("max cols", 2472, q)
         `CHK("phase", {x[5], x[0]}, ph)
         `CHK("depth", x[29:28], adc)
         bus(1, `IFM_REG_STATUS, 0); `CHK("status", {x[5], x[0]}, q)
         exp_q = {};
         got = {};
         n_sof = 0;
         n_eol = 0;
         for (i = rr; i < rr + orr; i++) for (j = rc; j < rc + oc; j++)
            exp_q.push_back(p1 ? pix(i - rr, j - rc, 1'b0, p1)
                            : pix(i * er, (x[0] ? nk - 1 - j : j) * ec, x[5], p0));
         @(posedge clk) start <= 1;
         @(posedge clk) start <= 0;
         @(posedge clk);
         while (busy !== 1'b0) @(posedge clk);
         repeat (20) @(posedge clk);
         `CHK("pixel count", exp_q.size(), got.size())
         foreach (exp_q[k]) `CHK("pixel", exp_q[k], got[k])
         `CHK("rows", orr, n_eol)
         `CHK("frame starts", 1, n_sof)
         $display("frame %0d done", f);
      end
      results;
   end
endmodule
bind ifm_format ifm_checker u_ifm_checker (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ROWS_REVERSED_O(ROWS_REVERSED_O),
   .ADC_DEPTH_O(ADC_DEPTH_O), .BIN_EN_O(BIN_EN_O), .BIN_H_O(BIN_H_O), .BIN_V_O(BIN_V_O),
   .BAYER_PHASE_O(BAYER_PHASE_O), .PIX_VALID_O(PIX_VALID_O), .PIX_SOF_O(PIX_SOF_O),
   .PIX_EOL_O(PIX_EOL_O));
`default_nettype wire
